// [logic/flash_ctrl_pkg.sv]
// Constants, state encoding and state record of the flash sequencer
package flash_ctrl_pkg;

  // Register port addresses
  localparam logic [11:0] ADDR_CTL = 12'hff8;
  localparam logic [11:0] ADDR_PSEL = 12'hff9;
  localparam logic [11:0] ADDR_FREQ_HI = 12'hffa;
  localparam logic [11:0] ADDR_FREQ_LO = 12'hffb;

  // Command codes
  localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] CMD_PROT_SEL = 8'h5e;

  // Array geometry
  localparam int PAGE_SHIFT = 9;
  localparam int PAGE_W = 7;
  localparam int FLASH_ADDR_W = 13;
  localparam int SECTOR_SHIFT = (FLASH_ADDR_W - 3 > PAGE_SHIFT) ?
                                (FLASH_ADDR_W - 3) : PAGE_SHIFT;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Status field codes
  localparam logic [5:0] STAT_LOCKED = 6'h00;
  localparam logic [5:0] STAT_UNLK1 = 6'h01;
  localparam logic [5:0] STAT_UNLK2 = 6'h02;
  localparam logic [5:0] STAT_UNLOCKED = 6'h03;
  localparam logic [5:0] STAT_PROT_SEL = 6'h04;
  localparam logic [5:0] STAT_PROGRAM = 6'h08;
  localparam logic [5:0] STAT_PAGE_ERASE = 6'h10;
  localparam logic [5:0] STAT_MASS_ERASE = 6'h20;

  // Timing: one tick is (kHz value >> TICK_SHIFT) cycles, 1/32 ms
  localparam int TICK_SHIFT = 5;
  localparam int TICKS_PER_MS = 32;
  localparam int PROG_TIME_US = 40;
  localparam int PAGE_ERASE_TIME_US = 10000;
  localparam int MASS_ERASE_TIME_US = 200000;
  localparam logic [15:0] PROG_TICKS =
    16'((PROG_TIME_US * TICKS_PER_MS + 999) / 1000);
  localparam logic [15:0] PAGE_ERASE_TICKS =
    16'((PAGE_ERASE_TIME_US * TICKS_PER_MS + 999) / 1000);
  localparam logic [15:0] MASS_ERASE_TICKS =
    16'((MASS_ERASE_TIME_US * TICKS_PER_MS + 999) / 1000);

  typedef enum logic [8:0] {
    ST_LOCKED     = 9'b000000001,
    ST_UNLK1      = 9'b000000010,
    ST_UNLK2      = 9'b000000100,
    ST_UNLOCKED   = 9'b000001000,
    ST_PROT_SEL   = 9'b000010000,
    ST_PROGRAM    = 9'b000100000,
    ST_PAGE_ERASE = 9'b001000000,
    ST_MASS_ERASE = 9'b010000000,
    ST_SPARE      = 9'b100000000
  } ctrl_state_e;

  typedef struct packed {
    ctrl_state_e st;
    logic [6:0] page;
    logic info_en;
    logic [6:0] active;
    logic [7:0] prot;
    logic [15:0] freq;
    logic [7:0] rdata;
    logic [15:0] fl_addr;
    logic [7:0] fl_wdata;
    logic merge;
    logic [15:0] pre;
    logic [15:0] ticks;
    logic dbg_stage;
    logic [7:0] dbg_rdata;
    logic dbg_rvalid;
    logic dbg_refused;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{
    st: ST_LOCKED, page: 7'h00, info_en: 1'b0, active: 7'h00,
    prot: 8'h00, freq: 16'h0000, rdata: 8'h00, fl_addr: 16'h0000,
    fl_wdata: 8'hff, merge: 1'b0, pre: 16'h0000, ticks: 16'h0000,
    dbg_stage: 1'b0, dbg_rdata: 8'h00, dbg_rvalid: 1'b0,
    dbg_refused: 1'b0};

endpackage : flash_ctrl_pkg

// [logic/flash_program_erase_ctrl.sv]
// Flash program/erase sequencer with lock and protection logic
`timescale 1ns/100ps

// Behaviour
// (RULE_01) Software loads frequency value as clock/1000
// (RULE_02) Program/erase only between 10 kHz, 20 MHz
// (RULE_03) Read-protect option refuses debugger flash reads
// (RULE_04) Both write options zero block user writes
// (RULE_05) Write option one enables program and erase
// (RULE_06) Reset leaves controller locked
// (RULE_07) Unlock: page, 73H, 8CH, same page
// (RULE_08) Mismatched page relocks; match makes page active
// (RULE_09) 95H erases page only if sector unprotected
// (RULE_10) Other command codes relock and end programming
// (RULE_11) Page stays unlocked after each byte
// (RULE_12) Eight sectors, never smaller than one page
// (RULE_13) 5EH while locked redirects next page write
// (RULE_14) Protect bits set sticky, block their sector
// (RULE_15) Programming needs unlock plus enabled erase mode
// (RULE_16) Programming only clears bits; erase gives FFH
// (RULE_17) Stall core during program and erase
// (RULE_18) Page erase fills page, then relocks
// (RULE_19) Debugger 63H mass erases, then relocks
// (RULE_20) Debugger polls status until operation ends
// (RULE_21) At most two programs per byte per erase
// (RULE_22) Debugger bypasses write and sector protection
// (RULE_23) Debugger: free protect bits, one page write
// (RULE_24) Only one page open at a time
// (RULE_25) Bad command or order relocks controller
// (RULE_26) Status field encodes controller state
// (RULE_27) Page field is program address bits 15:9
// (RULE_28) User writes outside active page ignored
module flash_program_erase_ctrl
  import flash_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pm_wr,
  input wire logic [15:0] pm_addr,
  input wire logic [7:0] pm_wdata,
  input wire logic dbg_mode,
  input wire logic dbg_rd,
  output logic [7:0] dbg_rdata,
  output logic dbg_rvalid,
  output logic dbg_read_refused,
  input wire logic read_protect_option,
  input wire logic hw_write_protect_option,
  input wire logic write_protect_option,
  output logic cpu_stall,
  output logic [15:0] fl_addr,
  output logic [7:0] fl_wdata,
  output logic fl_prog,
  output logic fl_page_erase,
  output logic fl_mass_erase,
  input wire logic [7:0] flash_rdata
);

  ctrl_s s;
  ctrl_s next_s;

  logic busy;
  logic wr_allowed;
  logic page_open;
  logic sect_open;
  logic active_sect_open;
  logic [15:0] reload;
  logic [15:0] op_ticks;
  logic [5:0] status;

  // Sector index of a page
  function automatic logic [2:0] sector_of(input logic [6:0] pg);
    logic [15:0] a;
    a = {pg, 9'h000};
    sector_of = 3'(a >> SECTOR_SHIFT); // [RULE_12]
  endfunction : sector_of

  assign busy = (s.st == ST_PROGRAM) || (s.st == ST_PAGE_ERASE) ||
                (s.st == ST_MASS_ERASE);

  // Hardware option only matters while the write option is zero,
  // and then every user write is blocked either way
  assign wr_allowed = dbg_mode | write_protect_option; // [RULE_04][RULE_05][RULE_22]
  assign page_open = dbg_mode |
                     (pm_addr[15:PAGE_SHIFT] == s.active); // [RULE_28][RULE_27]
  assign sect_open = dbg_mode |
                     !s.prot[sector_of(pm_addr[15:PAGE_SHIFT])]; // [RULE_14]
  assign active_sect_open = dbg_mode |
                            !s.prot[sector_of(s.active)]; // [RULE_09][RULE_22]

  assign reload = ((s.freq >> TICK_SHIFT) == 16'h0000) ? 16'h0001 :
                  (s.freq >> TICK_SHIFT);

  always_comb begin
    case (s.st)
      ST_PROGRAM: op_ticks = PROG_TICKS;
      ST_PAGE_ERASE: op_ticks = PAGE_ERASE_TICKS;
      ST_MASS_ERASE: op_ticks = MASS_ERASE_TICKS;
      default: op_ticks = 16'hffff;
    endcase
  end

  always_comb begin
    case (s.st)
      ST_LOCKED: status = STAT_LOCKED; // [RULE_26]
      ST_UNLK1: status = STAT_UNLK1;
      ST_UNLK2: status = STAT_UNLK2;
      ST_UNLOCKED: status = STAT_UNLOCKED;
      ST_PROT_SEL: status = STAT_PROT_SEL;
      ST_PROGRAM: status = STAT_PROGRAM;
      ST_PAGE_ERASE: status = STAT_PAGE_ERASE;
      ST_MASS_ERASE: status = STAT_MASS_ERASE;
      default: status = STAT_LOCKED;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    next_s.dbg_rvalid = 1'b0;
    next_s.dbg_refused = 1'b0;

    // Register reads, answered one cycle later
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTL: next_s.rdata = {2'b00, status};
        ADDR_PSEL: next_s.rdata = (s.st == ST_PROT_SEL) ? s.prot :
                                  {s.info_en, s.page};
        ADDR_FREQ_HI: next_s.rdata = s.freq[15:8];
        ADDR_FREQ_LO: next_s.rdata = s.freq[7:0];
        default: next_s.rdata = 8'h00;
      endcase
    end

    // Debugger flash read: address out, then data the next cycle
    if (s.dbg_stage) begin
      next_s.dbg_stage = 1'b0;
      next_s.dbg_rvalid = 1'b1;
      next_s.dbg_refused = read_protect_option; // [RULE_03]
      next_s.dbg_rdata = read_protect_option ? 8'h00 : flash_rdata; // [RULE_03]
    end

    if (busy) begin
      // Timed operation, paced by the loaded kHz value
      if (s.merge) begin
        // Only 1-to-0 changes reach the array
        next_s.merge = 1'b0;
        next_s.fl_wdata = s.fl_wdata & flash_rdata; // [RULE_16]
      end else if (s.ticks >= op_ticks) begin
        next_s.ticks = 16'h0000;
        next_s.pre = 16'h0000;
        next_s.fl_wdata = ERASED_BYTE;
        if (s.st == ST_PROGRAM) begin
          next_s.st = ST_UNLOCKED; // [RULE_11]
        end else begin
          next_s.st = ST_LOCKED; // [RULE_18][RULE_19]
        end
      end else if (s.pre == 16'h0000) begin
        next_s.pre = reload - 16'h0001;
        next_s.ticks = s.ticks + 16'h0001;
      end else begin
        next_s.pre = s.pre - 16'h0001;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_CTL: begin
          case (s.st)
            ST_LOCKED: begin
              if (reg_wdata == CMD_UNLOCK1) begin
                next_s.st = ST_UNLK1; // [RULE_07]
              end else if (reg_wdata == CMD_PROT_SEL) begin
                next_s.st = ST_PROT_SEL; // [RULE_13]
              end
            end
            ST_UNLK1: begin
              if (reg_wdata == CMD_UNLOCK2 && dbg_mode) begin
                next_s.st = ST_UNLOCKED; // [RULE_23]
                next_s.active = s.page;
              end else if (reg_wdata == CMD_UNLOCK2) begin
                next_s.st = ST_UNLK2; // [RULE_07]
              end else begin
                next_s.st = ST_LOCKED; // [RULE_25]
              end
            end
            ST_UNLOCKED: begin
              if (reg_wdata == CMD_PAGE_ERASE && wr_allowed &&
                  active_sect_open) begin
                next_s.st = ST_PAGE_ERASE; // [RULE_09][RULE_17]
                next_s.fl_addr = {s.active, 9'h000};
                next_s.fl_wdata = ERASED_BYTE;
                next_s.merge = 1'b0;
                next_s.pre = reload - 16'h0001;
                next_s.ticks = 16'h0000;
              end else if (reg_wdata == CMD_MASS_ERASE && dbg_mode) begin
                next_s.st = ST_MASS_ERASE; // [RULE_19][RULE_23]
                next_s.fl_addr = 16'h0000;
                next_s.fl_wdata = ERASED_BYTE;
                next_s.merge = 1'b0;
                next_s.pre = reload - 16'h0001;
                next_s.ticks = 16'h0000;
              end else begin
                next_s.st = ST_LOCKED; // [RULE_10][RULE_04]
              end
            end
            default: next_s.st = ST_LOCKED; // [RULE_25]
          endcase
        end
        ADDR_PSEL: begin
          if (s.st == ST_PROT_SEL) begin
            // User code can only add protection
            next_s.prot = dbg_mode ? reg_wdata :
                          (s.prot | reg_wdata); // [RULE_14][RULE_23]
            next_s.st = ST_LOCKED;
          end else begin
            next_s.page = reg_wdata[6:0]; // [RULE_27]
            next_s.info_en = reg_wdata[7];
            if (s.st == ST_UNLK2) begin
              if (reg_wdata[6:0] == s.page) begin
                next_s.st = ST_UNLOCKED; // [RULE_08][RULE_24]
                next_s.active = reg_wdata[6:0];
              end else begin
                next_s.st = ST_LOCKED; // [RULE_08]
              end
            end else if (s.st == ST_UNLOCKED && dbg_mode) begin
              next_s.active = reg_wdata[6:0]; // [RULE_23]
            end else if (s.st == ST_UNLK1) begin
              next_s.st = ST_LOCKED; // [RULE_25]
            end
          end
        end
        ADDR_FREQ_HI: next_s.freq[15:8] = reg_wdata; // [RULE_01]
        ADDR_FREQ_LO: next_s.freq[7:0] = reg_wdata; // [RULE_01]
        default: next_s.freq = s.freq;
      endcase
    end else if (pm_wr) begin
      // Byte program from the open page, or anywhere via debugger
      if (s.st == ST_UNLOCKED && wr_allowed && page_open &&
          sect_open) begin
        next_s.st = ST_PROGRAM; // [RULE_15][RULE_17]
        next_s.fl_addr = pm_addr;
        next_s.fl_wdata = pm_wdata;
        next_s.merge = 1'b1;
        next_s.pre = reload - 16'h0001;
        next_s.ticks = 16'h0000;
      end
    end else if (dbg_rd && dbg_mode) begin
      next_s.fl_addr = pm_addr;
      next_s.dbg_stage = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= CTRL_RESET; // [RULE_06]
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign dbg_rdata = s.dbg_rdata;
  assign dbg_rvalid = s.dbg_rvalid;
  assign dbg_read_refused = s.dbg_refused;
  assign cpu_stall = busy; // [RULE_17]
  assign fl_addr = s.fl_addr;
  assign fl_wdata = s.fl_wdata;
  assign fl_prog = (s.st == ST_PROGRAM) && !s.merge;
  assign fl_page_erase = (s.st == ST_PAGE_ERASE); // [RULE_18]
  assign fl_mass_erase = (s.st == ST_MASS_ERASE); // [RULE_19]

endmodule : flash_program_erase_ctrl

// [dv/flash_ctrl_chk.sv]
// Port-level assertions for the flash sequencer
`timescale 1ns/100ps
module flash_ctrl_chk
  import flash_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic pm_wr,
  input wire logic dbg_mode,
  input wire logic dbg_rd,
  input wire logic [7:0] dbg_rdata,
  input wire logic dbg_rvalid,
  input wire logic dbg_read_refused,
  input wire logic write_protect_option,
  input wire logic cpu_stall,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_prog,
  input wire logic fl_page_erase,
  input wire logic fl_mass_erase,
  input wire logic [7:0] flash_rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence dbg_req;
    dbg_rd && dbg_mode && !reg_wr && !cpu_stall;
  endsequence
  sequence dbg_ans;
    ##2 dbg_rvalid;
  endsequence
  AST_DBG_READ: assert property (dbg_req |-> dbg_ans)
    else $error("debug read unanswered");
  AST_REFUSED_ZERO: assert property (dbg_read_refused |-> dbg_rvalid && dbg_rdata == 8'h00)
    else $error("refused read leaks data");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  AST_STALL: assert property (fl_prog || fl_page_erase || fl_mass_erase |-> cpu_stall)
    else $error("core not stalled");
  AST_ONE_OP: assert property ($onehot0({fl_prog, fl_page_erase, fl_mass_erase}))
    else $error("overlapping operations");
  AST_USER_WP: assert property (pm_wr && !reg_wr && !cpu_stall && !dbg_mode && !write_protect_option |=> !cpu_stall)
    else $error("program despite protection");
  AST_MASS_USER: assert property (reg_wr && reg_addr == ADDR_CTL && reg_wdata == CMD_MASS_ERASE && !dbg_mode && !cpu_stall |=> !cpu_stall [*3])
    else $error("user mass erase started");
  AST_PROG_CLEARS: assert property (fl_prog |-> (fl_wdata & ~flash_rdata) == 8'h00)
    else $error("program sets bits");
  AST_ERASE_BASE: assert property (fl_page_erase |-> fl_addr[8:0] == 9'h000)
    else $error("page erase not page aligned");
  AST_MASS_BASE: assert property (fl_mass_erase |-> fl_addr == 16'h0000)
    else $error("mass erase address");
endmodule : flash_ctrl_chk

bind flash_program_erase_ctrl flash_ctrl_chk i_chk (.sys_clk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pm_wr, .dbg_mode,
  .dbg_rd, .dbg_rdata, .dbg_rvalid, .dbg_read_refused, .write_protect_option,
  .cpu_stall, .fl_addr, .fl_wdata, .fl_prog, .fl_page_erase, .fl_mass_erase,
  .flash_rdata);

// [dv/flash_array_model.sv]
// Behavioural flash array behind the sequencer
`timescale 1ns/100ps
module flash_array_model
  import flash_ctrl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_prog,
  input wire logic fl_page_erase,
  input wire logic fl_mass_erase,
  output logic [7:0] flash_rdata
);
  logic [7:0] mem [1 << FLASH_ADDR_W];
  logic pe_q = 1'b0;
  logic me_q = 1'b0;
  // Non-blank start so erases show
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h5a;
    end
  end
  assign flash_rdata = mem[fl_addr[FLASH_ADDR_W-1:0]];
  always @(posedge sys_clk) begin
    pe_q <= fl_page_erase;
    me_q <= fl_mass_erase;
    if (fl_prog) begin
      // Cells only discharge towards 0
      mem[fl_addr[FLASH_ADDR_W-1:0]] <= flash_rdata & fl_wdata;
    end
    if (fl_page_erase && !pe_q) begin
      for (int i = 0; i < 512; i++) begin
        mem[{fl_addr[FLASH_ADDR_W-1:PAGE_SHIFT], 9'(i)}] <= ERASED_BYTE;
      end
    end
    if (fl_mass_erase && !me_q) begin
      foreach (mem[i]) begin
        mem[i] <= ERASED_BYTE;
      end
    end
  end
endmodule : flash_array_model

// [dv/flash_program_erase_ctrl_test.sv]
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
module flash_program_erase_ctrl_test;
  import flash_ctrl_pkg::*;
  // Rows: page, cmd, cmd, page, status
  localparam logic [39:0] ROWS [4] = '{40'h02_73_8c_02_03,
    40'h02_73_8c_03_00, 40'h02_8c_73_02_00, 40'h02_73_95_02_00};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [15:0] pm_addr = 16'h0000;
  logic [7:0] pm_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, pm_wr = 1'b0, dbg_mode = 1'b0;
  logic dbg_rd = 1'b0, read_protect_option = 1'b0;
  logic hw_write_protect_option = 1'b0, write_protect_option = 1'b1;
  logic [7:0] reg_rdata, dbg_rdata, fl_wdata, flash_rdata;
  logic [15:0] fl_addr;
  logic dbg_rvalid, dbg_read_refused, cpu_stall;
  logic fl_prog, fl_page_erase, fl_mass_erase;
  int mismatches = 0;
  int total_checks = 0;
  flash_program_erase_ctrl i_dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pm_wr, .pm_addr, .pm_wdata, .dbg_mode,
    .dbg_rd, .dbg_rdata, .dbg_rvalid, .dbg_read_refused, .read_protect_option,
    .hw_write_protect_option, .write_protect_option, .cpu_stall, .fl_addr,
    .fl_wdata, .fl_prog, .fl_page_erase, .fl_mass_erase, .flash_rdata);
  flash_array_model i_flash (.sys_clk, .fl_addr, .fl_wdata, .fl_prog,
    .fl_page_erase, .fl_mass_erase, .flash_rdata);
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask : rd
  // Waits out a busy phase, bounded
  task automatic idle;
    for (int n = 0; n < 20000 && cpu_stall !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : idle
  task automatic pm(input logic [15:0] a, input logic [7:0] d, input logic b);
    @(posedge sys_clk);
    pm_addr <= a;
    pm_wdata <= d;
    pm_wr <= 1'b1;
    @(posedge sys_clk);
    pm_wr <= 1'b0;
    #1 chk(16'(cpu_stall), 16'(b));
    idle();
  endtask : pm
  task automatic unl(input logic [7:0] p, input logic both);
    wr(ADDR_PSEL, p);
    wr(ADDR_CTL, CMD_UNLOCK1);
    wr(ADDR_CTL, CMD_UNLOCK2);
    if (both) begin
      wr(ADDR_PSEL, p);
    end
  endtask : unl
  task automatic dr(input logic [15:0] a, input logic [7:0] e, input logic r);
    @(posedge sys_clk);
    pm_addr <= a;
    dbg_rd <= 1'b1;
    @(posedge sys_clk);
    dbg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(16'({dbg_rvalid, dbg_read_refused, dbg_rdata}), 16'({1'b1, r, e}));
  endtask : dr
  task automatic mem(input logic [12:0] a, input logic [7:0] e);
    chk(16'(i_flash.mem[a]), 16'(e));
  endtask : mem
  task automatic end_of_test;
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (40000) @(posedge sys_clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(ADDR_CTL, STAT_LOCKED);
    wr(ADDR_FREQ_LO, 8'h20);
    pm(16'h0405, 8'h00, 1'b0);
    foreach (ROWS[i]) begin
      wr(ADDR_PSEL, ROWS[i][39:32]);
      wr(ADDR_CTL, ROWS[i][31:24]);
      wr(ADDR_CTL, ROWS[i][23:16]);
      wr(ADDR_PSEL, ROWS[i][15:8]);
      rd(ADDR_CTL, ROWS[i][7:0]);
      wr(ADDR_CTL, CMD_MASS_ERASE);
      #1 chk(16'(cpu_stall), 16'h0000);
      rd(ADDR_CTL, STAT_LOCKED);
    end
    hw_write_protect_option <= 1'b1;
    unl(8'h02, 1'b1);
    pm(16'h0405, 8'h0f, 1'b1);
    mem(13'h0405, 8'h0a);
    pm(16'h0406, 8'hf0, 1'b1);
    pm(16'h0405, 8'hff, 1'b1);
    mem(13'h0405, 8'h0a);
    pm(16'h0605, 8'h00, 1'b0);
    mem(13'h0605, 8'h5a);
    hw_write_protect_option <= 1'b0;
    write_protect_option <= 1'b0;
    pm(16'h0407, 8'h00, 1'b0);
    write_protect_option <= 1'b1;
    wr(ADDR_CTL, CMD_PAGE_ERASE);
    rd(ADDR_CTL, STAT_PAGE_ERASE);
    idle();
    mem(13'h0406, 8'hff);
    mem(13'h05ff, 8'hff);
    mem(13'h0605, 8'h5a);
    rd(ADDR_CTL, STAT_LOCKED);
    wr(ADDR_CTL, CMD_PROT_SEL);
    rd(ADDR_CTL, STAT_PROT_SEL);
    wr(ADDR_PSEL, 8'h01);
    wr(ADDR_CTL, CMD_PROT_SEL);
    wr(ADDR_PSEL, 8'h00);
    wr(ADDR_CTL, CMD_PROT_SEL);
    rd(ADDR_PSEL, 8'h01);
    wr(ADDR_PSEL, 8'h00);
    unl(8'h00, 1'b1);
    pm(16'h0010, 8'h00, 1'b0);
    wr(ADDR_CTL, CMD_PAGE_ERASE);
    #1 chk(16'(cpu_stall), 16'h0000);
    mem(13'h0010, 8'h5a);
    dbg_mode <= 1'b1;
    write_protect_option <= 1'b0;
    unl(8'h00, 1'b0);
    rd(ADDR_CTL, STAT_UNLOCKED);
    pm(16'h0811, 8'h33, 1'b1);
    pm(16'h0011, 8'h00, 1'b1);
    mem(13'h0811, 8'h12);
    dr(16'h0001, 8'h5a, 1'b0);
    read_protect_option <= 1'b1;
    dr(16'h0001, 8'h00, 1'b1);
    wr(ADDR_CTL, CMD_MASS_ERASE);
    rd(ADDR_CTL, STAT_MASS_ERASE);
    idle();
    mem(13'h1fff, 8'hff);
    mem(13'h0011, 8'hff);
    rd(ADDR_CTL, STAT_LOCKED);
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    wr(ADDR_CTL, CMD_PROT_SEL);
    rd(ADDR_PSEL, 8'h00);
    end_of_test();
  end
endmodule : flash_program_erase_ctrl_test
